// >>> hw/csu_top.sv
/*
  Cam main shaft setup: settings registers, range warning, axis selection alarm,
  input sign handling, clutch with smoothing, cam cycle position and cam number choice.
  Assumes a single-cycle register port master and encoder/servo deltas synchronous to core_clk.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "csu_consts.svh"
module csu_top (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic [`CSU_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic signed [7:0]      enc_pulse_delta,
  input  wire logic signed [31:0]     servo_delta,
  input  wire logic signed [31:0]     comp_delta,
  input  wire logic                   clutch_cmd,
  output logic signed [31:0]          cam_input_delta,
  output logic      [19:0]            cam_cycle_pos,
  output logic      [3:0]             cam_active,
  output logic                        cam_control_warning,
  output logic                        parameter_alarm,
  output logic                        irq
);

  csu_pkg::csu_cfg_t cfg;
  csu_pkg::csu_cfg_t next_cfg;
  csu_pkg::csu_env_t env;
  csu_pkg::csu_env_t next_env;
  logic [`CSU_IRQ_W-1:0] irq_status;
  logic [`CSU_IRQ_W-1:0] next_irq_status;
  logic [`CSU_IRQ_W-1:0] irq_mask;
  logic [`CSU_IRQ_W-1:0] next_irq_mask;
  logic [31:0] next_reg_rdata;

  logic [`CSU_RATIO_W-1:0] eff_numer;
  logic [`CSU_RATIO_W-1:0] eff_denom;
  logic                    ratio_bad;
  logic signed [31:0]      enc_axis_delta;

  csu_pkg::csu_clutch_state_t cl_state;
  csu_pkg::csu_clutch_state_t next_cl_state;
  logic [15:0] gain;
  logic [15:0] next_gain;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic signed [31:0] next_cam_input_delta;
  logic [19:0] next_cam_cycle_pos;
  logic [3:0]  next_cam_active;
  logic        next_warning;
  logic        next_alarm;

  logic signed [31:0] main_raw;
  logic signed [31:0] main_signed;
  logic signed [31:0] sub_signed;
  logic signed [47:0] scaled;
  logic signed [31:0] total;
  logic               cycle_wrap;
  logic signed [31:0] pos_sum;
  logic               alarm_now;

  localparam logic [15:0] GAIN_FULL = 16'h8000;
  localparam logic [15:0] TICKS_PER_MS = `CSU_TICKS_PER_MS;

  csu_ratio_check u_ratio (
    .numer        (cfg.numer),
    .denom        (cfg.denom),
    .eff_numer    (eff_numer),
    .eff_denom    (eff_denom),
    .out_of_range (ratio_bad)
  );

  csu_scaler u_scaler (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .pulse_delta (enc_pulse_delta),
    .numer       (eff_numer),
    .denom       (eff_denom),
    .axis_delta  (enc_axis_delta)
  );

  // Register writes; out-of-range writes to checked fields are ignored, so those fields keep legal codes
  always_comb begin
    next_cfg      = cfg;
    next_env      = env;
    next_irq_mask = irq_mask;
    if (reg_wr) begin
      case (reg_addr)
        `CSU_OFF_NUMER: begin
          next_cfg.numer = reg_wdata[`CSU_RATIO_W-1:0];
        end
        `CSU_OFF_DENOM: begin
          next_cfg.denom = reg_wdata[`CSU_RATIO_W-1:0];
        end
        `CSU_OFF_AXIS: begin
          if (reg_wdata[1:0] != 2'h3) begin
            next_cfg.axis = csu_pkg::csu_axis_t'(reg_wdata[1:0]);
          end
        end
        `CSU_OFF_SIGN: begin
          if (reg_wdata[`CSU_SIGN_MAIN_LSB+:2] != 2'h3) begin
            next_cfg.main_sign = csu_pkg::csu_sign_t'(reg_wdata[`CSU_SIGN_MAIN_LSB+:2]);
          end
          if (reg_wdata[`CSU_SIGN_SUB_LSB+:2] != 2'h3) begin
            next_cfg.sub_sign = csu_pkg::csu_sign_t'(reg_wdata[`CSU_SIGN_SUB_LSB+:2]);
          end
        end
        `CSU_OFF_CLUTCH: begin
          next_cfg.clutch_mode = reg_wdata[0];
          next_cfg.smooth_sel  = reg_wdata[`CSU_CLUTCH_SMM_BIT];
        end
        `CSU_OFF_SMOOTH_TIME: begin
          if (reg_wdata[12:0] <= `CSU_SMOOTH_MAX && reg_wdata[31:13] == '0) begin
            next_cfg.smooth_time = reg_wdata[12:0];
          end
        end
        `CSU_OFF_CYCLE_LEN: begin
          if (reg_wdata[19:0] <= `CSU_CYCLE_MAX && reg_wdata[31:20] == '0) begin
            next_cfg.cycle_len = reg_wdata[19:0];
          end
        end
        `CSU_OFF_CAM_SEL: begin
          if (reg_wdata[3:0] <= `CSU_CAM_MAX && reg_wdata[31:4] == '0) begin
            next_cfg.cam_sel = reg_wdata[3:0];
          end
        end
        `CSU_OFF_REMOTE_CAM: begin
          next_cfg.remote_cam = reg_wdata[3:0];
        end
        `CSU_OFF_ENV: begin
          next_env.scale_mode   = reg_wdata[`CSU_ENV_SCALE_BIT];
          next_env.diff_encoder = reg_wdata[`CSU_ENV_DIFF_BIT];
          next_env.std_mode     = reg_wdata[`CSU_ENV_STD_BIT];
        end
        `CSU_OFF_IRQ_MASK: begin
          next_irq_mask = reg_wdata[`CSU_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg      <= '0;
      env      <= '0;
      irq_mask <= '0;
    end else begin
      cfg      <= next_cfg;
      env      <= next_env;
      irq_mask <= next_irq_mask;
    end
  end

  // Shaft input path
  always_comb begin
    alarm_now = (cfg.axis == csu_pkg::CSU_AXIS_ENC) &&
                (!env.scale_mode || !env.diff_encoder || !env.std_mode);
    case (cfg.axis)
      csu_pkg::CSU_AXIS_SERVO: main_raw = servo_delta;
      csu_pkg::CSU_AXIS_ENC:   main_raw = alarm_now ? 32'sh0 : enc_axis_delta;
      default:                 main_raw = 32'sh0;
    endcase
    case (cfg.main_sign)
      csu_pkg::CSU_SIGN_PLUS:  main_signed = main_raw;
      csu_pkg::CSU_SIGN_MINUS: main_signed = -main_raw;
      default:                 main_signed = 32'sh0;
    endcase
    case (cfg.sub_sign)
      csu_pkg::CSU_SIGN_PLUS:  sub_signed = comp_delta;
      csu_pkg::CSU_SIGN_MINUS: sub_signed = -comp_delta;
      default:                 sub_signed = 32'sh0;
    endcase
    // Gain is Q1.15; full gain means clutch fully engaged
    scaled = 48'(main_signed) * $signed({32'h0, gain});
    total  = 32'(scaled >>> 15) + sub_signed;
    next_cam_input_delta = total;
  end

  // Clutch engagement and exponential smoothing
  always_comb begin
    next_cl_state = cl_state;
    next_gain     = gain;
    next_tick     = tick;
    case (cl_state)
      csu_pkg::CSU_CL_OFF: begin
        next_gain = '0;
        if (!cfg.clutch_mode || clutch_cmd) begin
          next_cl_state = cfg.smooth_sel ? csu_pkg::CSU_CL_RAMP : csu_pkg::CSU_CL_ON;
          next_tick     = '0;
          next_gain     = cfg.smooth_sel ? 16'h0000 : GAIN_FULL;
        end
      end
      csu_pkg::CSU_CL_RAMP: begin
        next_tick = tick + 16'h1;
        if (cfg.clutch_mode && !clutch_cmd) begin
          next_cl_state = csu_pkg::CSU_CL_OFF;
          next_gain     = '0;
        end else if (!cfg.smooth_sel || cfg.smooth_time == '0 || gain >= GAIN_FULL - 16'h1) begin
          next_cl_state = csu_pkg::CSU_CL_ON;
          next_gain     = GAIN_FULL;
        end else if (tick >= TICKS_PER_MS - 16'h1) begin
          next_tick = '0;
          // Each ms closes a 1/time_constant share of the gap, approximating exp(-t/T)
          next_gain = gain + 16'(({16'h0, GAIN_FULL - gain} + 32'(cfg.smooth_time) - 32'h1) /
                                 32'(cfg.smooth_time));
        end
      end
      csu_pkg::CSU_CL_ON: begin
        next_gain = GAIN_FULL;
        if (cfg.clutch_mode && !clutch_cmd) begin
          next_cl_state = csu_pkg::CSU_CL_OFF;
          next_gain     = '0;
        end
      end
      default: begin
        next_cl_state = csu_pkg::CSU_CL_OFF;
        next_gain     = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cl_state <= csu_pkg::CSU_CL_OFF;
      gain     <= '0;
      tick     <= '0;
    end else begin
      cl_state <= next_cl_state;
      gain     <= next_gain;
      tick     <= next_tick;
    end
  end

  // Cycle position, cam choice and alarm outputs
  always_comb begin
    pos_sum    = $signed({12'h0, cam_cycle_pos}) + cam_input_delta;
    cycle_wrap = 1'b0;
    if (cfg.cycle_len == '0) begin
      next_cam_cycle_pos = '0;
    end else if (pos_sum >= $signed({12'h0, cfg.cycle_len})) begin
      next_cam_cycle_pos = 20'(pos_sum - $signed({12'h0, cfg.cycle_len}));
      cycle_wrap         = 1'b1;
    end else if (pos_sum < 32'sh0) begin
      next_cam_cycle_pos = 20'(pos_sum + $signed({12'h0, cfg.cycle_len}));
      cycle_wrap         = 1'b1;
    end else begin
      next_cam_cycle_pos = 20'(pos_sum);
    end
    if (cfg.cam_sel == '0) begin
      next_cam_active = (cfg.remote_cam <= `CSU_CAM_MAX) ? cfg.remote_cam : cam_active;
    end else begin
      next_cam_active = cfg.cam_sel;
    end
    next_warning = ratio_bad;
    next_alarm   = alarm_now;
    // Set wins over a write-one-to-clear in the same cycle
    next_irq_status = irq_status;
    if (reg_wr && reg_addr == `CSU_OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~reg_wdata[`CSU_IRQ_W-1:0];
    end
    next_irq_status[`CSU_IRQ_WARN_BIT]  = next_irq_status[`CSU_IRQ_WARN_BIT] | (ratio_bad & ~cam_control_warning);
    next_irq_status[`CSU_IRQ_ALARM_BIT] = next_irq_status[`CSU_IRQ_ALARM_BIT] | (alarm_now & ~parameter_alarm);
    next_irq_status[`CSU_IRQ_CYCLE_BIT] = next_irq_status[`CSU_IRQ_CYCLE_BIT] | cycle_wrap;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cam_input_delta     <= '0;
      cam_cycle_pos       <= '0;
      cam_active          <= '0;
      cam_control_warning <= 1'b0;
      parameter_alarm     <= 1'b0;
      irq_status          <= '0;
    end else begin
      cam_input_delta     <= next_cam_input_delta;
      cam_cycle_pos       <= next_cam_cycle_pos;
      cam_active          <= next_cam_active;
      cam_control_warning <= next_warning;
      parameter_alarm     <= next_alarm;
      irq_status          <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read port
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `CSU_OFF_NUMER:       next_reg_rdata = {8'h00, cfg.numer};
        `CSU_OFF_DENOM:       next_reg_rdata = {8'h00, cfg.denom};
        `CSU_OFF_AXIS:        next_reg_rdata = {30'h0, cfg.axis};
        `CSU_OFF_SIGN:        next_reg_rdata = {26'h0, cfg.sub_sign, 2'h0, cfg.main_sign};
        `CSU_OFF_CLUTCH:      next_reg_rdata = {27'h0, cfg.smooth_sel, 3'h0, cfg.clutch_mode};
        `CSU_OFF_SMOOTH_TIME: next_reg_rdata = {19'h0, cfg.smooth_time};
        `CSU_OFF_CYCLE_LEN:   next_reg_rdata = {12'h0, cfg.cycle_len};
        `CSU_OFF_CAM_SEL:     next_reg_rdata = {28'h0, cfg.cam_sel};
        `CSU_OFF_REMOTE_CAM:  next_reg_rdata = {28'h0, cfg.remote_cam};
        `CSU_OFF_ENV:         next_reg_rdata = {29'h0, env.std_mode, env.diff_encoder, env.scale_mode};
        `CSU_OFF_STATUS:      next_reg_rdata = {24'h0, cam_active, cl_state == csu_pkg::CSU_CL_ON,
                                                1'b0, parameter_alarm, cam_control_warning};
        `CSU_OFF_IRQ_STATUS:  next_reg_rdata = {29'h0, irq_status};
        `CSU_OFF_IRQ_MASK:    next_reg_rdata = {29'h0, irq_mask};
        `CSU_OFF_PULSES:      next_reg_rdata = enc_axis_delta;
        `CSU_OFF_AXIS_POS:    next_reg_rdata = {12'h0, cam_cycle_pos};
        default:              next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// >>> hw/csu_consts.svh
/*
  Register offsets, field positions, reset values and limits for the cam main shaft setup block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CSU_CONSTS_SVH
`define CSU_CONSTS_SVH

`define CSU_ADDR_W            8
`define CSU_OFF_NUMER         8'h00
`define CSU_OFF_DENOM         8'h04
`define CSU_OFF_AXIS          8'h08
`define CSU_OFF_SIGN          8'h0c
`define CSU_OFF_CLUTCH        8'h10
`define CSU_OFF_SMOOTH_TIME   8'h14
`define CSU_OFF_CYCLE_LEN     8'h18
`define CSU_OFF_CAM_SEL       8'h1c
`define CSU_OFF_REMOTE_CAM    8'h20
`define CSU_OFF_ENV           8'h24
`define CSU_OFF_STATUS        8'h28
`define CSU_OFF_IRQ_STATUS    8'h2c
`define CSU_OFF_IRQ_MASK      8'h30
`define CSU_OFF_PULSES        8'h34
`define CSU_OFF_AXIS_POS      8'h38

`define CSU_RATIO_W           24
`define CSU_RATIO_MAX         24'hffffff
`define CSU_RATIO_LO_DIV      16'h3e80
`define CSU_RATIO_HI_MUL      16'h1770
`define CSU_SMOOTH_MAX        13'h1388
`define CSU_CYCLE_MAX         20'hf423f
`define CSU_CAM_MAX           4'h8
`define CSU_RESET_VAL         32'h0000_0000
`define CSU_TICKS_PER_MS      16'hc350

`define CSU_SIGN_MAIN_LSB     0
`define CSU_SIGN_SUB_LSB      4
`define CSU_ENV_SCALE_BIT     0
`define CSU_ENV_DIFF_BIT      1
`define CSU_ENV_STD_BIT       2
`define CSU_CLUTCH_SMM_BIT    4

`define CSU_IRQ_WARN_BIT      0
`define CSU_IRQ_ALARM_BIT     1
`define CSU_IRQ_CYCLE_BIT     2
`define CSU_IRQ_W             3

`endif

// >>> hw/csu_pkg.sv
/*
  Types for the cam main shaft setup block.
  Assumes csu_consts.svh is on the include path.
*/
`include "csu_consts.svh"

package csu_pkg;

  typedef enum logic [1:0] {
    CSU_AXIS_OFF   = 2'h0,
    CSU_AXIS_SERVO = 2'h1,
    CSU_AXIS_ENC   = 2'h2
  } csu_axis_t;

  typedef enum logic [1:0] {
    CSU_SIGN_PLUS  = 2'h0,
    CSU_SIGN_MINUS = 2'h1,
    CSU_SIGN_NONE  = 2'h2
  } csu_sign_t;

  typedef enum logic [2:0] {
    CSU_CL_OFF     = 3'h1,
    CSU_CL_ON      = 3'h2,
    CSU_CL_RAMP    = 3'h4
  } csu_clutch_state_t;

  typedef struct packed {
    logic [`CSU_RATIO_W-1:0] numer;
    logic [`CSU_RATIO_W-1:0] denom;
    csu_axis_t               axis;
    csu_sign_t               main_sign;
    csu_sign_t               sub_sign;
    logic                    clutch_mode;
    logic                    smooth_sel;
    logic [12:0]             smooth_time;
    logic [19:0]             cycle_len;
    logic [3:0]              cam_sel;
    logic [3:0]              remote_cam;
  } csu_cfg_t;

  typedef struct packed {
    logic scale_mode;
    logic diff_encoder;
    logic std_mode;
  } csu_env_t;

endpackage

// >>> hw/csu_ratio_check.sv
/*
  Ratio window check for the encoder conversion pair, and effective numerator and denominator.
  Assumes raw register values; purely combinational.
*/
`timescale 1ns/1ns
`include "csu_consts.svh"
module csu_ratio_check (
  input  wire logic [`CSU_RATIO_W-1:0] numer,
  input  wire logic [`CSU_RATIO_W-1:0] denom,
  output logic      [`CSU_RATIO_W-1:0] eff_numer,
  output logic      [`CSU_RATIO_W-1:0] eff_denom,
  output logic                         out_of_range
);

  logic [39:0] lo_lhs;
  logic [39:0] hi_rhs;

  always_comb begin
    eff_numer = (numer == '0) ? `CSU_RATIO_W'(1) : numer;
    eff_denom = (denom == '0) ? `CSU_RATIO_W'(1) : denom;
    // Cross-multiplied so no divider is needed
    lo_lhs = 40'(eff_numer) * 40'(`CSU_RATIO_LO_DIV);
    hi_rhs = 40'(eff_denom) * 40'(`CSU_RATIO_HI_MUL);
    out_of_range = (lo_lhs < 40'(eff_denom)) || (40'(eff_numer) > hi_rhs);
  end

endmodule

// >>> hw/csu_scaler.sv
/*
  Scales encoder pulse counts into synchronous encoder axis units with remainder carry.
  Assumes a nonzero denominator and one pulse delta per clock.
*/
`timescale 1ns/1ns
`include "csu_consts.svh"
module csu_scaler (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic signed [7:0]       pulse_delta,
  input  wire logic [`CSU_RATIO_W-1:0] numer,
  input  wire logic [`CSU_RATIO_W-1:0] denom,
  output logic signed [31:0]           axis_delta
);

  logic signed [47:0] acc;
  logic signed [47:0] next_acc;
  logic signed [31:0] next_axis_delta;
  logic signed [47:0] sum;
  logic signed [47:0] den_s;
  logic signed [47:0] quot;

  always_comb begin
    den_s = $signed({24'h000000, denom});
    sum   = acc + 48'(pulse_delta) * $signed({24'h000000, numer});
    quot  = sum / den_s;
    next_acc        = sum - quot * den_s;
    next_axis_delta = 32'(quot);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc        <= '0;
      axis_delta <= '0;
    end else begin
      acc        <= next_acc;
      axis_delta <= next_axis_delta;
    end
  end

endmodule

// >>> verif/csu_top_checker.sv
/*
  Concurrent checks on the ports of csu_top, bound in at the foot of this file.
  Assumes the register map of csu_top; settings are shadowed from the write port.
*/
`timescale 1ns/1ns

module csu_top_checker (
  input wire logic               core_clk,
  input wire logic               arst_n,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic signed [7:0]  enc_pulse_delta,
  input wire logic signed [31:0] servo_delta,
  input wire logic signed [31:0] comp_delta,
  input wire logic               clutch_cmd,
  input wire logic signed [31:0] cam_input_delta,
  input wire logic [19:0]        cam_cycle_pos,
  input wire logic [3:0]         cam_active,
  input wire logic               cam_control_warning,
  input wire logic               parameter_alarm,
  input wire logic               irq
);
  logic [23:0] numer_sh;
  logic [23:0] denom_sh;
  logic [1:0]  axis_sh;
  logic [2:0]  env_sh;
  logic [2:0]  mask_sh;
  logic [39:0] n_eff;
  logic [39:0] d_eff;
  logic        warn_exp;
  logic        alarm_exp;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Shadows let the flags be predicted from the write port alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      numer_sh <= '0;
      denom_sh <= '0;
      axis_sh  <= '0;
      env_sh   <= '0;
      mask_sh  <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h00: numer_sh <= reg_wdata[23:0];
        8'h04: denom_sh <= reg_wdata[23:0];
        8'h08: if (reg_wdata[1:0] != 2'h3) axis_sh <= reg_wdata[1:0];
        8'h24: env_sh <= reg_wdata[2:0];
        8'h30: mask_sh <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    n_eff     = (numer_sh == 24'h0) ? 40'h1 : {16'h0, numer_sh};
    d_eff     = (denom_sh == 24'h0) ? 40'h1 : {16'h0, denom_sh};
    warn_exp  = (n_eff * 40'h3e80 < d_eff) || (n_eff > d_eff * 40'h1770);
    alarm_exp = (axis_sh == 2'h2) && (env_sh != 3'h7);
  end

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_unmapped_read_zero: assert property (reg_rd && reg_addr > 8'h38 |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_warn_follows_ratio: assert property (cam_control_warning == $past(warn_exp))
    else $error("warning does not match ratio window");
  a_alarm_follows_env: assert property (parameter_alarm == $past(alarm_exp))
    else $error("alarm does not match axis choice");
  a_cam_sel_direct: assert property (reg_wr && reg_addr == 8'h1c && reg_wdata != 32'h0 && reg_wdata <= 32'h8
    ##1 !(reg_wr && reg_addr == 8'h1c) |=> cam_active == $past(reg_wdata[3:0], 2))
    else $error("cam number setting not applied");
  a_status_read_flags: assert property (reg_rd && reg_addr == 8'h28 |=>
    reg_rdata[7:4] == $past(cam_active) && reg_rdata[1:0] == {$past(parameter_alarm), $past(cam_control_warning)})
    else $error("status read disagrees with outputs");
  a_irq_all_masked: assert property (mask_sh == 3'h0 |-> !irq)
    else $error("interrupt raised while fully masked");
  a_reset_outputs_clear: assert property ($rose(arst_n) |->
    cam_active == 4'h0 && cam_cycle_pos == 20'h0 && !cam_control_warning && !parameter_alarm)
    else $error("outputs not clear after reset");
endmodule

bind csu_top csu_top_checker chk_u (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_pulse_delta(enc_pulse_delta),
  .servo_delta(servo_delta), .comp_delta(comp_delta), .clutch_cmd(clutch_cmd),
  .cam_input_delta(cam_input_delta), .cam_cycle_pos(cam_cycle_pos), .cam_active(cam_active),
  .cam_control_warning(cam_control_warning), .parameter_alarm(parameter_alarm), .irq(irq)
);

// >>> verif/csu_feed_model.sv
/*
  Far-side source model: encoder pulses, servo input, compensation and clutch command.
  Assumes the bench sets the wanted per-cycle amounts; outputs move only after a clock edge.
*/
`timescale 1ns/1ns

module csu_feed_model (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic signed [7:0]  enc_set,
  input  wire logic signed [31:0] srv_set,
  input  wire logic signed [31:0] cmp_set,
  input  wire logic               clu_set,
  output logic signed [7:0]       enc_pulse_delta,
  output logic signed [31:0]      servo_delta,
  output logic signed [31:0]      comp_delta,
  output logic                    clutch_cmd
);
  // Registered so each amount is launched just after an edge, as a real source would
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_pulse_delta <= '0;
      servo_delta     <= '0;
      comp_delta      <= '0;
      clutch_cmd      <= 1'b0;
    end else begin
      enc_pulse_delta <= enc_set;
      servo_delta     <= srv_set;
      comp_delta      <= cmp_set;
      clutch_cmd      <= clu_set;
    end
  end
endmodule

// >>> verif/testbench.sv
/*
  Self-checking bench for csu_top: register tasks on the plain port, scenario sequence, verdict.
  Assumes csu_feed_model supplies the per-cycle inputs and the checker is bound in.
*/
`timescale 1ns/1ns

module testbench;
  logic               core_clk, arst_n, reg_wr, reg_rd, clu_set, clutch_cmd, irq;
  logic               cam_control_warning, parameter_alarm;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_rdata, reg_wdata, v;
  logic signed [7:0]  enc_set, enc_pulse_delta;
  logic signed [31:0] srv_set, cmp_set, servo_delta, comp_delta, cam_input_delta;
  logic [19:0]        cam_cycle_pos, p;
  logic [3:0]         cam_active;
  int                 err_count, n_checks;
  int                 fs[3] = '{1, -1, 0};
  logic [23:0]        tn[8] = '{24'h0, 24'h1, 24'h1, 24'h1770, 24'h1771, 24'h0, 24'h1771, 24'hffffff};
  logic [23:0]        td[8] = '{24'h0, 24'h3e80, 24'h3e81, 24'h1, 24'h1, 24'h3e81, 24'h0, 24'hffffff};
  logic [7:0]         tw = 8'h74;

  csu_feed_model feed_u (.core_clk(core_clk), .arst_n(arst_n), .enc_set(enc_set), .srv_set(srv_set),
    .cmp_set(cmp_set), .clu_set(clu_set), .enc_pulse_delta(enc_pulse_delta), .servo_delta(servo_delta),
    .comp_delta(comp_delta), .clutch_cmd(clutch_cmd));
  csu_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_pulse_delta(enc_pulse_delta),
    .servo_delta(servo_delta), .comp_delta(comp_delta), .clutch_cmd(clutch_cmd),
    .cam_input_delta(cam_input_delta), .cam_cycle_pos(cam_cycle_pos), .cam_active(cam_active),
    .cam_control_warning(cam_control_warning), .parameter_alarm(parameter_alarm), .irq(irq));

  task automatic summarize;
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // Outputs are compared mid-cycle, away from the edge that moves them
  task automatic at(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic alarm_case(input logic [31:0] ax, input logic [31:0] env, input logic [31:0] exp);
    wr(8'h08, ax);
    wr(8'h24, env);
    at(2);
    chk({31'h0, parameter_alarm}, exp);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, clu_set, reg_addr, reg_wdata} = '0;
    {enc_set, srv_set, cmp_set} = '0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4) begin
      rd(8'(a), v);
      chk(v, 32'h0);
    end
    wr(8'h40, 32'h5);
    rd(8'h40, v);
    chk(v, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {8'h0, tn[i]});
      wr(8'h04, {8'h0, td[i]});
      at(2);
      chk({31'h0, cam_control_warning}, {31'h0, tw[i]});
    end
    rd(8'h2c, v);
    chk(v & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h30, 32'h1);
    at(1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h2c, 32'h1);
    at(1);
    chk({31'h0, irq}, 32'h0);
    alarm_case(32'h1, 32'h0, 32'h0);
    alarm_case(32'h2, 32'h0, 32'h1);
    alarm_case(32'h3, 32'h0, 32'h1);
    alarm_case(32'h2, 32'h3, 32'h1);
    alarm_case(32'h2, 32'h5, 32'h1);
    rd(8'h28, v);
    chk(v & 32'h2, 32'h2);
    alarm_case(32'h2, 32'h7, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h0);
    @(posedge core_clk) enc_set <= 8'sd3;
    at(4);
    chk(cam_input_delta, 32'h6);
    rd(8'h34, v);
    chk(v, 32'h6);
    wr(8'h08, 32'h1);
    @(posedge core_clk) begin
      enc_set <= 8'sd0;
      srv_set <= 32'sd5;
      cmp_set <= 32'sd3;
    end
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 3; s++) begin
        wr(8'h0c, 32'(s * 16 + m));
        at(3);
        chk(cam_input_delta, 32'(fs[m] * 5 + fs[s] * 3));
      end
    end
    // Refused codes must leave the plus/plus setting in place
    wr(8'h0c, 32'h0);
    wr(8'h0c, 32'h33);
    at(3);
    chk(cam_input_delta, 32'h8);
    wr(8'h08, 32'h0);
    at(3);
    chk(cam_input_delta, 32'h3);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h20);
    wr(8'h10, 32'h1);
    at(3);
    chk(cam_input_delta, 32'h0);
    @(posedge core_clk) clu_set <= 1'b1;
    at(3);
    chk(cam_input_delta, 32'h5);
    wr(8'h10, 32'h11);
    at(3);
    chk(cam_input_delta, 32'h5);
    @(posedge core_clk) clu_set <= 1'b0;
    wr(8'h14, 32'h1388);
    at(3);
    chk(cam_input_delta, 32'h0);
    @(posedge core_clk) clu_set <= 1'b1;
    at(10);
    chk(cam_input_delta, 32'h0);
    wr(8'h14, 32'h1389);
    rd(8'h14, v);
    chk(v, 32'h1388);
    wr(8'h10, 32'h1);
    at(3);
    chk(cam_input_delta, 32'h5);
    // Time constant zero engages without smoothing, one ramp cycle later than select zero
    wr(8'h10, 32'h11);
    wr(8'h14, 32'h0);
    @(posedge core_clk) clu_set <= 1'b0;
    @(posedge core_clk) clu_set <= 1'b1;
    at(5);
    chk(cam_input_delta, 32'h5);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'hc);
    wr(8'h18, 32'hf4240);
    rd(8'h18, v);
    chk(v, 32'hc);
    for (int k = 0; k < 15; k++) begin
      p = cam_cycle_pos;
      at(0);
      chk({12'h0, cam_cycle_pos}, {12'h0, 20'((p + 20'h5) % 20'hc)});
    end
    rd(8'h2c, v);
    chk(v & 32'h4, 32'h4);
    wr(8'h20, 32'h5);
    at(2);
    chk({28'h0, cam_active}, 32'h5);
    wr(8'h1c, 32'h3);
    wr(8'h20, 32'h7);
    at(2);
    chk({28'h0, cam_active}, 32'h3);
    wr(8'h1c, 32'h8);
    at(2);
    chk({28'h0, cam_active}, 32'h8);
    wr(8'h1c, 32'h9);
    at(2);
    chk({28'h0, cam_active}, 32'h8);
    wr(8'h1c, 32'h0);
    at(2);
    chk({28'h0, cam_active}, 32'h7);
    summarize();
  end
endmodule
